// ==== verilog/gef_pkg.sv ====
// Purpose: shared constants and types for the port E / port F gpio block
// Assumes: AXI4-Lite 32-bit slave, one clock, active-low asynchronous reset
// Notes: register index times four gives the byte address
package gef_pkg;

   // ==========================================================================
   // bus geometry and answers
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W = 6;
   localparam int IDX_LSB = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================================
   // register indices (byte address = index * 4)
   localparam logic [IDX_W-1:0] IDX_PORT_E_DATA = 6'h08;
   localparam logic [IDX_W-1:0] IDX_PORT_F_DATA = 6'h09;
   localparam logic [IDX_W-1:0] IDX_OPTICAL = 6'h1C;
   localparam logic [IDX_W-1:0] IDX_PORT_E_DIR = 6'h20;
   localparam logic [IDX_W-1:0] IDX_PORT_F_DIR = 6'h21;

   // ==========================================================================
   // port widths and shared pin positions
   localparam int PE_W = 5;
   localparam int PF_W = 8;
   localparam int PE_OPT_W = 4;
   localparam int PIN_TIMER_EXTERNAL_CLOCK_PIN = 0;
   localparam int PIN_TIMER_CHANNEL_0_PIN = 1;
   localparam int PIN_TIMER_CHANNEL_1_PIN = 2;

   // ==========================================================================
   // reset values
   localparam logic [PE_W-1:0] PE_DIR_RESET = 5'h00;
   localparam logic [PF_W-1:0] PF_DIR_RESET = 8'h00;
   localparam logic [7:0] OPTICAL_RESET = 8'h00;

   // ==========================================================================
   // optical register layout, bit 7 down to bit 0
   typedef struct packed {
      logic [2:0] slice_level_y;
      logic [2:0] slice_level_x;
      logic optical_enable_y;
      logic optical_enable_x;
   } gef_opt_s;

   // slicing level in millivolts: base plus code times step
   localparam int MV_W = 10;
   localparam logic [MV_W-1:0] SLICE_BASE_MV = 10'h0C8;
   localparam logic [MV_W-1:0] SLICE_STEP_MV = 10'h064;

   // ==========================================================================
   // timer hookup; edge_level pairs are {select_b, select_a}
   localparam logic [1:0] ELS_GPIO = 2'h0;
   localparam logic [2:0] PS_EXT_CLK_DEFAULT = 3'h7;

   typedef struct packed {
      logic [1:0] edge_level_ch1;
      logic [1:0] edge_level_ch0;
      logic [2:0] timer_prescale_select;
      logic ch1_out;
      logic ch1_drive;
      logic ch0_out;
      logic ch0_drive;
   } gef_tim_s;

   // ==========================================================================
   // bus state machines
   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } gef_wr_e;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } gef_rd_e;

endpackage

// ==== verilog/gef_ports.sv ====
// Purpose: port E (5 pins, optical front end on 3..0) and port F (8 pins) gpio
// Assumes: pins synchronous to mclk; timer and keyboard units live elsewhere
// Notes: data latches hold no reset; direction and optical control do
//
// Contract
// - port E direction one drives the pin, zero makes it input
// - reset clears all port E direction bits
// - port E data read gives latch if output, pin level if input
// - data writes always load latches; input pins still read the pin
// - timer owns pin direction when claimed; direction still picks read source
// - port E pins 1 and 2 become timer channels when edge/level claims
// - port E pin 0 feeds timer clock when prescale selects it
// - port E pull-ups 3..0 enabled only for input pins
// - port E key enables turn pins 3..0 into interrupt inputs
// - optical register holds enables in bits 1..0, levels in 7..2
// - X enable powers optical front end and divider for pins 0,1
// - Y enable powers optical front end and divider for pins 2,3
// - level codes 0..7 select 200 to 900 mV in 100 mV steps
// - port F direction one drives the pin, zero makes it input
// - reset clears port F direction, leaves port F latches alone
// - port F data read gives latch if output, pin level if input
// - port F pull-ups enabled only for input pins
// - port F key enables turn pins into interrupt inputs
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module gef_ports (
   input wire logic mclk,
   input wire logic rst_b,
   // axi4-lite slave
   input wire logic [gef_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [gef_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [gef_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [gef_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // port E pins; oe_b low while driving
   input wire logic [gef_pkg::PE_W-1:0] pe_pin_in,
   output logic [gef_pkg::PE_W-1:0] pe_pin_out,
   output logic [gef_pkg::PE_W-1:0] pe_pin_oe_b,
   // port F pins
   input wire logic [gef_pkg::PF_W-1:0] pf_pin_in,
   output logic [gef_pkg::PF_W-1:0] pf_pin_out,
   output logic [gef_pkg::PF_W-1:0] pf_pin_oe_b,
   // timer unit hookup
   input wire gef_pkg::gef_tim_s tim_cfg,
   output logic timer_channel_0_pin,
   output logic timer_channel_1_pin,
   output logic timer_external_clock_pin,
   output logic timer_ext_clk_selected,
   // keyboard unit hookup
   input wire logic [gef_pkg::PE_OPT_W-1:0] port_e_key_irq_enable,
   input wire logic [gef_pkg::PF_W-1:0] port_f_key_irq_enable,
   input wire logic [gef_pkg::PE_OPT_W-1:0] port_e_pullup_enables,
   input wire logic [gef_pkg::PF_W-1:0] port_f_pullup_enables,
   output logic [gef_pkg::PE_OPT_W-1:0] pe_key_level,
   output logic [gef_pkg::PF_W-1:0] pf_key_level,
   output logic [gef_pkg::PE_OPT_W-1:0] pe_pullup_on,
   output logic [gef_pkg::PF_W-1:0] pf_pullup_on,
   // analog optical front end controls
   output logic optical_enable_x,
   output logic optical_enable_y,
   output logic divider_enable_x,
   output logic divider_enable_y,
   output logic [2:0] slice_level_x,
   output logic [2:0] slice_level_y,
   output logic [gef_pkg::MV_W-1:0] slice_mv_x,
   output logic [gef_pkg::MV_W-1:0] slice_mv_y
);

   // ==========================================================================
   // state
   gef_pkg::gef_wr_e wr_st_q, wr_st_d;
   gef_pkg::gef_rd_e rd_st_q, rd_st_d;
   logic aw_have_q, aw_have_d;
   logic w_have_q, w_have_d;
   logic [gef_pkg::ADDR_W-1:0] aw_addr_q, aw_addr_d;
   logic [gef_pkg::DATA_W-1:0] w_data_q, w_data_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic [1:0] bresp_q, bresp_d;
   logic [gef_pkg::DATA_W-1:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [gef_pkg::PE_W-1:0] pe_dir_q, pe_dir_d;
   logic [gef_pkg::PF_W-1:0] pf_dir_q, pf_dir_d;
   gef_pkg::gef_opt_s opt_q, opt_d;
   logic [gef_pkg::PE_W-1:0] pe_latch_q, pe_latch_d;
   logic [gef_pkg::PF_W-1:0] pf_latch_q, pf_latch_d;

   // combinational helpers
   logic aw_fire, w_fire, ar_fire;
   logic wr_go;
   logic [gef_pkg::ADDR_W-1:0] wr_addr;
   logic [gef_pkg::DATA_W-1:0] wr_data;
   logic [3:0] wr_strb;
   logic [gef_pkg::IDX_W-1:0] wr_idx, rd_idx;
   logic wr_lane0;
   logic ch0_claim, ch1_claim, clk_claim;
   logic [gef_pkg::PE_W-1:0] pe_timer_own;
   logic [gef_pkg::PE_W-1:0] pe_timer_drive;
   logic [gef_pkg::PE_W-1:0] pe_timer_out;
   logic [gef_pkg::PE_W-1:0] pe_read_val;
   logic [gef_pkg::PF_W-1:0] pf_read_val;

   // ==========================================================================
   // bus handshakes; one write and one read in flight at most
   assign awready = (wr_st_q == gef_pkg::WR_IDLE) && !aw_have_q;
   assign wready = (wr_st_q == gef_pkg::WR_IDLE) && !w_have_q;
   assign arready = (rd_st_q == gef_pkg::RD_IDLE);
   assign aw_fire = awvalid && awready;
   assign w_fire = wvalid && wready;
   assign ar_fire = arvalid && arready;
   assign bvalid = (wr_st_q == gef_pkg::WR_RESP);
   assign rvalid = (rd_st_q == gef_pkg::RD_DATA);
   assign bresp = bresp_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;

   // address and data may arrive in either order; merge held and live halves
   assign wr_go = (wr_st_q == gef_pkg::WR_IDLE) && (aw_have_q || aw_fire) && (w_have_q || w_fire);
   assign wr_addr = aw_have_q ? aw_addr_q : awaddr;
   assign wr_data = w_have_q ? w_data_q : wdata;
   assign wr_strb = w_have_q ? w_strb_q : wstrb;
   assign wr_idx = wr_addr[gef_pkg::IDX_LSB +: gef_pkg::IDX_W];
   assign rd_idx = araddr[gef_pkg::IDX_LSB +: gef_pkg::IDX_W];
   // every register sits in byte lane 0, so only that strobe matters
   assign wr_lane0 = wr_go && wr_strb[0];

   // ==========================================================================
   // timer ownership of shared pins
   assign ch0_claim = (tim_cfg.edge_level_ch0 != gef_pkg::ELS_GPIO);
   assign ch1_claim = (tim_cfg.edge_level_ch1 != gef_pkg::ELS_GPIO);
   assign clk_claim = (tim_cfg.timer_prescale_select == gef_pkg::PS_EXT_CLK_DEFAULT);

   always_comb begin
      pe_timer_own = '0;
      pe_timer_drive = '0;
      pe_timer_out = '0;
      // clock input is never driven while claimed
      pe_timer_own[gef_pkg::PIN_TIMER_EXTERNAL_CLOCK_PIN] = clk_claim;
      pe_timer_own[gef_pkg::PIN_TIMER_CHANNEL_0_PIN] = ch0_claim;
      pe_timer_drive[gef_pkg::PIN_TIMER_CHANNEL_0_PIN] = tim_cfg.ch0_drive;
      pe_timer_out[gef_pkg::PIN_TIMER_CHANNEL_0_PIN] = tim_cfg.ch0_out;
      pe_timer_own[gef_pkg::PIN_TIMER_CHANNEL_1_PIN] = ch1_claim;
      pe_timer_drive[gef_pkg::PIN_TIMER_CHANNEL_1_PIN] = tim_cfg.ch1_drive;
      pe_timer_out[gef_pkg::PIN_TIMER_CHANNEL_1_PIN] = tim_cfg.ch1_out;
   end

   // pin levels go to the timer as plain levels; it qualifies them itself
   assign timer_channel_0_pin = pe_pin_in[gef_pkg::PIN_TIMER_CHANNEL_0_PIN];
   assign timer_channel_1_pin = pe_pin_in[gef_pkg::PIN_TIMER_CHANNEL_1_PIN];
   assign timer_external_clock_pin = pe_pin_in[gef_pkg::PIN_TIMER_EXTERNAL_CLOCK_PIN];
   assign timer_ext_clk_selected = clk_claim;

   // ==========================================================================
   // pin drivers; the timer overrides direction on claimed pins
   always_comb begin
      for (int i = 0; i < gef_pkg::PE_W; i++) begin
         if (pe_timer_own[i]) begin
            pe_pin_out[i] = pe_timer_out[i];
            pe_pin_oe_b[i] = !pe_timer_drive[i];
         end else begin
            pe_pin_out[i] = pe_latch_q[i];
            pe_pin_oe_b[i] = !pe_dir_q[i];
         end
      end
   end

   assign pf_pin_out = pf_latch_q;
   assign pf_pin_oe_b = ~pf_dir_q;

   // ==========================================================================
   // read sources: latch for outputs, pin for inputs, even on timer pins
   assign pe_read_val = (pe_dir_q & pe_latch_q) | (~pe_dir_q & pe_pin_in);
   assign pf_read_val = (pf_dir_q & pf_latch_q) | (~pf_dir_q & pf_pin_in);

   // ==========================================================================
   // pull-ups only while the pin is an input; key levels idle high when off
   assign pe_pullup_on = port_e_pullup_enables & ~pe_dir_q[gef_pkg::PE_OPT_W-1:0];
   assign pf_pullup_on = port_f_pullup_enables & ~pf_dir_q;
   assign pe_key_level = pe_pin_in[gef_pkg::PE_OPT_W-1:0] | ~port_e_key_irq_enable;
   assign pf_key_level = pf_pin_in | ~port_f_key_irq_enable;

   // ==========================================================================
   // optical front end; divider follows its pair's enable
   assign optical_enable_x = opt_q.optical_enable_x;
   assign divider_enable_x = opt_q.optical_enable_x;
   assign optical_enable_y = opt_q.optical_enable_y;
   assign divider_enable_y = opt_q.optical_enable_y;
   assign slice_level_x = opt_q.slice_level_x;
   assign slice_level_y = opt_q.slice_level_y;
   // 100 mV per code step, 200 mV at code zero
   assign slice_mv_x = gef_pkg::SLICE_BASE_MV + 10'(opt_q.slice_level_x * gef_pkg::SLICE_STEP_MV);
   assign slice_mv_y = gef_pkg::SLICE_BASE_MV + 10'(opt_q.slice_level_y * gef_pkg::SLICE_STEP_MV);

   // ==========================================================================
   // write channel next state
   always_comb begin
      wr_st_d = wr_st_q;
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      aw_addr_d = aw_addr_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bresp_d = bresp_q;
      case (wr_st_q)
         gef_pkg::WR_IDLE: begin
            if (wr_go) begin
               aw_have_d = 1'b0;
               w_have_d = 1'b0;
               wr_st_d = gef_pkg::WR_RESP;
               case (wr_idx)
                  gef_pkg::IDX_PORT_E_DATA,
                  gef_pkg::IDX_PORT_F_DATA,
                  gef_pkg::IDX_OPTICAL,
                  gef_pkg::IDX_PORT_E_DIR,
                  gef_pkg::IDX_PORT_F_DIR: bresp_d = gef_pkg::RESP_OKAY;
                  default: bresp_d = gef_pkg::RESP_SLVERR;
               endcase
            end else begin
               // park whichever half came first
               if (aw_fire) begin
                  aw_have_d = 1'b1;
                  aw_addr_d = awaddr;
               end
               if (w_fire) begin
                  w_have_d = 1'b1;
                  w_data_d = wdata;
                  w_strb_d = wstrb;
               end
            end
         end
         gef_pkg::WR_RESP: begin
            if (bready) begin
               wr_st_d = gef_pkg::WR_IDLE;
            end
         end
         default: begin
            wr_st_d = gef_pkg::WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_st_q <= gef_pkg::WR_IDLE;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         bresp_q <= gef_pkg::RESP_OKAY;
      end else begin
         wr_st_q <= wr_st_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         aw_addr_q <= aw_addr_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bresp_q <= bresp_d;
      end
   end

   // ==========================================================================
   // read channel next state; data is sampled at the address edge
   always_comb begin
      rd_st_d = rd_st_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      case (rd_st_q)
         gef_pkg::RD_IDLE: begin
            if (ar_fire) begin
               rd_st_d = gef_pkg::RD_DATA;
               rdata_d = '0;
               rresp_d = gef_pkg::RESP_OKAY;
               case (rd_idx)
                  gef_pkg::IDX_PORT_E_DATA: rdata_d[gef_pkg::PE_W-1:0] = pe_read_val;
                  gef_pkg::IDX_PORT_F_DATA: rdata_d[gef_pkg::PF_W-1:0] = pf_read_val;
                  gef_pkg::IDX_OPTICAL: rdata_d[7:0] = opt_q;
                  gef_pkg::IDX_PORT_E_DIR: rdata_d[gef_pkg::PE_W-1:0] = pe_dir_q;
                  gef_pkg::IDX_PORT_F_DIR: rdata_d[gef_pkg::PF_W-1:0] = pf_dir_q;
                  default: rresp_d = gef_pkg::RESP_SLVERR;
               endcase
            end
         end
         gef_pkg::RD_DATA: begin
            if (rready) begin
               rd_st_d = gef_pkg::RD_IDLE;
            end
         end
         default: begin
            rd_st_d = gef_pkg::RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_st_q <= gef_pkg::RD_IDLE;
         rdata_q <= '0;
         rresp_q <= gef_pkg::RESP_OKAY;
      end else begin
         rd_st_q <= rd_st_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // ==========================================================================
   // control registers: direction and optical, cleared by reset
   always_comb begin
      pe_dir_d = pe_dir_q;
      pf_dir_d = pf_dir_q;
      opt_d = opt_q;
      if (wr_lane0) begin
         case (wr_idx)
            gef_pkg::IDX_PORT_E_DIR: pe_dir_d = wr_data[gef_pkg::PE_W-1:0];
            gef_pkg::IDX_PORT_F_DIR: pf_dir_d = wr_data[gef_pkg::PF_W-1:0];
            gef_pkg::IDX_OPTICAL: opt_d = wr_data[7:0];
            default: begin
               pe_dir_d = pe_dir_q;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pe_dir_q <= gef_pkg::PE_DIR_RESET;
         pf_dir_q <= gef_pkg::PF_DIR_RESET;
         opt_q <= gef_pkg::OPTICAL_RESET;
      end else begin
         pe_dir_q <= pe_dir_d;
         pf_dir_q <= pf_dir_d;
         opt_q <= opt_d;
      end
   end

   // ==========================================================================
   // data latches: written whatever the direction, untouched by reset
   always_comb begin
      pe_latch_d = pe_latch_q;
      pf_latch_d = pf_latch_q;
      if (wr_lane0 && (wr_idx == gef_pkg::IDX_PORT_E_DATA)) begin
         pe_latch_d = wr_data[gef_pkg::PE_W-1:0];
      end
      if (wr_lane0 && (wr_idx == gef_pkg::IDX_PORT_F_DATA)) begin
         pf_latch_d = wr_data[gef_pkg::PF_W-1:0];
      end
   end

   // no reset on purpose: software may preload before enabling outputs
   always_ff @(posedge mclk) begin
      pe_latch_q <= pe_latch_d;
      pf_latch_q <= pf_latch_d;
   end

endmodule

// ==== verif/gef_pin_model.sv ====
// Purpose: far-side pin model for both ports
// Assumes: one driver per pin
// Notes: a released pin shows the outside level
`timescale 1ns/1ps
module gef_pin_model (
   input [4:0] pe_pin_out,
   input [4:0] pe_pin_oe_b,
   input [4:0] pe_ext,
   output logic [4:0] pe_pin_in,
   input [7:0] pf_pin_out,
   input [7:0] pf_pin_oe_b,
   input [7:0] pf_ext,
   output logic [7:0] pf_pin_in
);
   // ======
   // wire level: block wins while its enable is low
   assign pe_pin_in = (pe_pin_out & ~pe_pin_oe_b) | (pe_ext & pe_pin_oe_b);
   assign pf_pin_in = (pf_pin_out & ~pf_pin_oe_b) | (pf_ext & pf_pin_oe_b);
endmodule

// ==== verif/gef_ports_checker.sv ====
// Purpose: concurrent checks on the gpio ports
// Assumes: one clock domain, rst_b active low
// Notes: writes judged when aw and w land together
`timescale 1ns/1ps
module gef_ports_checker (
   input mclk,
   input rst_b,
   input [7:0] awaddr,
   input awvalid,
   input awready,
   input [31:0] wdata,
   input wvalid,
   input wready,
   input [4:0] pe_pin_in,
   input [4:0] pe_pin_oe_b,
   input [7:0] pf_pin_in,
   input [7:0] pf_pin_oe_b,
   input gef_pkg::gef_tim_s tim_cfg,
   input timer_channel_0_pin,
   input timer_external_clock_pin,
   input timer_ext_clk_selected,
   input [7:0] port_f_key_irq_enable,
   input [7:0] port_f_pullup_enables,
   input [7:0] pf_key_level,
   input [7:0] pf_pullup_on,
   input optical_enable_x,
   input optical_enable_y,
   input divider_enable_x,
   input divider_enable_y,
   input [2:0] slice_level_x,
   input [2:0] slice_level_y,
   input [9:0] slice_mv_x
);
   logic wr_take;
   // ======
   // helpers; split writes not judged
   assign wr_take = awvalid && awready && wvalid && wready;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ======
   // assertions
   a_reset_inputs: assert property (disable iff (1'b0) !rst_b |-> &{pe_pin_oe_b, pf_pin_oe_b})
      else $error("pin driven in reset");
   a_pe_dir_drive: assert property (wr_take && awaddr == 8'h80 |=> pe_pin_oe_b[4:3] == ~$past(wdata[4:3]))
      else $error("pe oe vs direction");
   a_pf_dir_drive: assert property (wr_take && awaddr == 8'h84 |=> pf_pin_oe_b == ~$past(wdata[7:0]))
      else $error("pf oe vs direction");
   a_opt_layout: assert property (wr_take && awaddr == 8'h70 |=>
      {slice_level_y, slice_level_x, optical_enable_y, optical_enable_x} == $past(wdata[7:0]))
      else $error("optical fields");
   a_divider_follow: assert property (divider_enable_x == optical_enable_x && divider_enable_y == optical_enable_y)
      else $error("divider vs enable");
   a_slice_mv: assert property (slice_mv_x == 10'h0C8 + 10'h064 * {7'h00, slice_level_x})
      else $error("slice mv wrong");
   a_timer_feed: assert property (timer_external_clock_pin == pe_pin_in[0] && timer_channel_0_pin == pe_pin_in[1]
      && timer_ext_clk_selected == (tim_cfg.timer_prescale_select == 3'h7))
      else $error("timer feed wrong");
   a_ch0_claim: assert property (tim_cfg.edge_level_ch0 != 2'h0 |-> pe_pin_oe_b[1] == !tim_cfg.ch0_drive)
      else $error("ch0 pin not timer owned");
   a_pf_pullup: assert property (pf_pullup_on == (port_f_pullup_enables & pf_pin_oe_b))
      else $error("pf pullup wrong");
   a_pf_key: assert property (pf_key_level == (pf_pin_in | ~port_f_key_irq_enable))
      else $error("pf key wrong");
   c_opt_write: cover property (wr_take && awaddr == 8'h70);
   c_ch0_claim: cover property (tim_cfg.edge_level_ch0 != 2'h0);
   c_ext_clk: cover property (timer_ext_clk_selected);
endmodule

// ==== verif/gef_ports_tb_top.sv ====
// Purpose: self-checking bench for the gpio block
// Assumes: bench is the bus master, far side modelled
// Notes: bus waits end at a handshake or the cycle ceiling
`timescale 1ns/1ps
module gef_ports_tb_top;
   logic mclk = 1'b0, rst_b;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [2:0] awprot = 3'h0, arprot = 3'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [4:0] pe_pin_in, pe_pin_out, pe_pin_oe_b, pe_ext = 5'h00;
   logic [7:0] pf_pin_in, pf_pin_out, pf_pin_oe_b, pf_ext = 8'h00;
   gef_pkg::gef_tim_s tim_cfg = 11'h000;
   logic timer_channel_0_pin, timer_channel_1_pin, timer_external_clock_pin, timer_ext_clk_selected;
   logic [3:0] port_e_key_irq_enable = 4'h0, port_e_pullup_enables = 4'h0, pe_key_level, pe_pullup_on;
   logic [7:0] port_f_key_irq_enable = 8'h00, port_f_pullup_enables = 8'h00, pf_key_level, pf_pullup_on;
   logic optical_enable_x, optical_enable_y, divider_enable_x, divider_enable_y;
   logic [2:0] slice_level_x, slice_level_y;
   logic [9:0] slice_mv_x, slice_mv_y;
   int bad_count, total_checks, cycles;

   // ======
   // clock, design and pin model
   always #4 mclk = ~mclk;
   gef_ports dut (.mclk, .rst_b, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .pe_pin_in, .pe_pin_out, .pe_pin_oe_b, .pf_pin_in, .pf_pin_out, .pf_pin_oe_b, .tim_cfg,
      .timer_channel_0_pin, .timer_channel_1_pin, .timer_external_clock_pin, .timer_ext_clk_selected,
      .port_e_key_irq_enable, .port_f_key_irq_enable, .port_e_pullup_enables, .port_f_pullup_enables,
      .pe_key_level, .pf_key_level, .pe_pullup_on, .pf_pullup_on, .optical_enable_x, .optical_enable_y,
      .divider_enable_x, .divider_enable_y, .slice_level_x, .slice_level_y, .slice_mv_x, .slice_mv_y);
   gef_pin_model pins (.pe_pin_out, .pe_pin_oe_b, .pe_ext, .pe_pin_in, .pf_pin_out, .pf_pin_oe_b, .pf_ext,
      .pf_pin_in);

   // ======
   // shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // aw and w offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   // ======
   // scenarios
   task automatic t_reset_values;
      @(negedge mclk);
      check("pe_oe_b", pe_pin_oe_b, 32'h1F);
      check("pf_oe_b", pf_pin_oe_b, 32'hFF);
      rdr(8'h80);
      check("pe_dir", rd, 32'h0);
      rdr(8'h84);
      check("pf_dir", rd, 32'h0);
   endtask
   task automatic t_port_e;
      @(posedge mclk);
      pe_ext <= 5'h15;
      port_e_pullup_enables <= 4'hF;
      port_e_key_irq_enable <= 4'h5;
      wr(8'h20, 32'h0A);
      rdr(8'h20);
      check("pe_read_in", rd, 32'h15);
      wr(8'h80, 32'h0C);
      rdr(8'h80);
      check("pe_dir", rd, 32'h0C);
      rdr(8'h20);
      check("pe_read_mix", rd, 32'h19);
      @(negedge mclk);
      check("pe_oe_b", pe_pin_oe_b, 32'h13);
      check("pe_out", pe_pin_out & 5'h0C, 32'h08);
      check("pe_pullup", pe_pullup_on, 32'h3);
      check("pe_key", pe_key_level, 32'hB);
   endtask
   task automatic t_port_f;
      @(posedge mclk);
      pf_ext <= 8'hA5;
      port_f_pullup_enables <= 8'hFF;
      port_f_key_irq_enable <= 8'h0F;
      wr(8'h24, 32'h3C);
      rdr(8'h24);
      check("pf_read_in", rd, 32'hA5);
      wr(8'h84, 32'hF0);
      rdr(8'h84);
      check("pf_dir", rd, 32'hF0);
      rdr(8'h24);
      check("pf_read_mix", rd, 32'h35);
      @(negedge mclk);
      check("pf_oe_b", pf_pin_oe_b, 32'h0F);
      check("pf_pullup", pf_pullup_on, 32'h0F);
      check("pf_key", pf_key_level, 32'hF5);
   endtask
   // reset in mid-run: direction cleared, latches kept
   task automatic t_mid_reset;
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      @(negedge mclk);
      check("pf_latch", pf_pin_out, 32'h3C);
      check("pf_oe_b", pf_pin_oe_b, 32'hFF);
      check("pe_oe_b", pe_pin_oe_b, 32'h1F);
   endtask
   task automatic t_optical;
      logic [7:0] v;
      for (int c = 0; c < 8; c++) begin
         v = {3'(7 - c), 3'(c), c[0], ~c[0]};
         wr(8'h70, {24'h0, v});
         rdr(8'h70);
         check("opt_back", rd, {24'h0, v});
         @(negedge mclk);
         check("levels", {slice_level_y, slice_level_x}, 32'(((7 - c) << 3) | c));
         check("mv_x", slice_mv_x, 32'(200 + 100 * c));
         check("mv_y", slice_mv_y, 32'(900 - 100 * c));
         check("en_x", {divider_enable_x, optical_enable_x}, {2{~c[0]}});
         check("en_y", {divider_enable_y, optical_enable_y}, {2{c[0]}});
      end
   endtask
   task automatic t_timer;
      wr(8'h20, 32'h00);
      wr(8'h80, 32'h1F);
      @(posedge mclk);
      pe_ext <= 5'h1F;
      tim_cfg <= 11'h4F3; // ch0 claimed driving high, ch1 claimed as input, clock pin claimed
      rdr(8'h20);
      check("pe_read_latch", rd, 32'h0);
      @(negedge mclk);
      check("tim_oe_b", pe_pin_oe_b, 32'h05);
      check("ch0_drive", pe_pin_out[1], 32'h1);
      check("tim_feed", {timer_ext_clk_selected, timer_external_clock_pin, timer_channel_1_pin}, 32'h7);
      @(posedge mclk);
      tim_cfg <= 11'h000;
      @(negedge mclk);
      check("gpio_oe_b", pe_pin_oe_b, 32'h00);
      check("gpio_out", pe_pin_out, 32'h00);
   endtask
   task automatic t_unmapped;
      wr(8'h40, 32'hFF);
      check("bresp", rs, 32'h2);
      rdr(8'h40);
      check("rresp", rs, 32'h2);
      check("rdata", rd, 32'h0);
   endtask

   // ======
   // run control
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ceiling far above the run's hundred-odd cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         end_of_test();
      end
   end
   initial begin
      // a real falling edge, so the design resets before the first clock
      rst_b <= 1'b0;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset_values();
      t_port_e();
      t_port_f();
      t_mid_reset();
      t_optical();
      t_timer();
      t_unmapped();
      end_of_test();
   end
endmodule

bind gef_ports gef_ports_checker chk (.mclk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready,
   .pe_pin_in, .pe_pin_oe_b, .pf_pin_in, .pf_pin_oe_b, .tim_cfg, .timer_channel_0_pin,
   .timer_external_clock_pin, .timer_ext_clk_selected, .port_f_key_irq_enable, .port_f_pullup_enables,
   .pf_key_level, .pf_pullup_on, .optical_enable_x, .optical_enable_y, .divider_enable_x, .divider_enable_y,
   .slice_level_x, .slice_level_y, .slice_mv_x);
